// ---- core/bias_apd_pkg.sv ----
package bias_apd_pkg;

	// ----------------------------------------------------------------
	// register map (printed offsets are word indices, byte = 4 * index)
	// ----------------------------------------------------------------
	localparam int           NUM_REGS      = 7;
	localparam logic [7:0]   IDX_CFG       = 8'h42;
	localparam logic [7:0]   IDX_APD_EN    = 8'h43;
	localparam logic [7:0]   IDX_A_CONV_LO = 8'h44;
	localparam logic [7:0]   IDX_A_CONV_HI = 8'h45;
	localparam logic [7:0]   IDX_A_SW_LO   = 8'h46;
	localparam logic [7:0]   IDX_A_SW_HI   = 8'h47;
	localparam logic [7:0]   IDX_B_CONV_LO = 8'h48;

	// storage slot numbers
	localparam int SLOT_CFG       = 0;
	localparam int SLOT_APD_EN    = 1;
	localparam int SLOT_A_CONV_LO = 2;
	localparam int SLOT_A_CONV_HI = 3;
	localparam int SLOT_A_SW_LO   = 4;
	localparam int SLOT_A_SW_HI   = 5;
	localparam int SLOT_B_CONV_LO = 6;

	localparam logic [7:0] REG_INDEX [NUM_REGS] = '{IDX_CFG, IDX_APD_EN, IDX_A_CONV_LO,
		IDX_A_CONV_HI, IDX_A_SW_LO, IDX_A_SW_HI, IDX_B_CONV_LO};
	localparam logic [15:0] REG_RESET [NUM_REGS] = '{16'h0000, 16'haaff, 16'h0000,
		16'h1833, 16'h0000, 16'h1833, 16'h0000};
	// writable bits; reserved bits read as zero
	localparam logic [15:0] REG_WMASK [NUM_REGS] = '{16'h500f, 16'hffff, 16'h0133,
		16'h3833, 16'h0133, 16'h3833, 16'h0133};

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int GRP_B_BIPOLAR_SEL   = 14;
	localparam int GRP_A_BIPOLAR_SEL   = 12;
	localparam int CLAMP_SRC_LSB       = 0;
	localparam int SW_PD_MODE_LSB      = 8;
	localparam int CONV_PD_ENABLE_LSB  = 0;
	// source register, low half
	localparam int TEMP_ALARM_ROUTE    = 8;
	localparam int EXT_IN1_ALARM_ROUTE = 5;
	localparam int EXT_IN0_ALARM_ROUTE = 4;
	localparam int ISENSE1_ALARM_ROUTE = 1;
	localparam int ISENSE0_ALARM_ROUTE = 0;
	// source register, high half
	localparam int ALARM_PIN_ROUTE     = 13;
	localparam int VREF_ALARM_ROUTE    = 12;
	localparam int THERMAL_ERR_ROUTE   = 11;
	localparam int NEG_SUPPLY_B_ROUTE  = 5;
	localparam int NEG_SUPPLY_A_ROUTE  = 4;
	localparam int POS_SUPPLY_B_ROUTE  = 1;
	localparam int POS_SUPPLY_A_ROUTE  = 0;

	// switch auto-power-down codes
	localparam logic [1:0] SW_PD_IGNORE = 2'h0;
	localparam logic [1:0] SW_PD_TO_NEG = 2'h2;
	localparam logic [1:0] SW_PD_CLAMP  = 2'h3;

	// alarm input vector layout
	localparam int ALARM_W = 12;
	localparam int ALM_TEMP = 0;
	localparam int ALM_EXT_IN1 = 1;
	localparam int ALM_EXT_IN0 = 2;
	localparam int ALM_ISENSE1 = 3;
	localparam int ALM_ISENSE0 = 4;
	localparam int ALM_PIN = 5;
	localparam int ALM_VREF = 6;
	localparam int ALM_THERMAL_ERR = 7;
	localparam int ALM_NEG_SUPPLY_B = 8;
	localparam int ALM_NEG_SUPPLY_A = 9;
	localparam int ALM_POS_SUPPLY_B = 10;
	localparam int ALM_POS_SUPPLY_A = 11;

	// bus constants
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0]  HSIZE_WORD    = 3'h2;
	localparam logic        HRESP_OKAY    = 1'b0;

endpackage

// ---- core/bias_auto_powerdown_cfg.sv ----
// Contract
// RULE_01: bit 14 picks group B polarity
// RULE_02: bit 12 picks group A polarity
// RULE_03: clamp bits 3,2 pick B switch clamp
// RULE_04: clamp bits 1,0 pick A switch clamp
// RULE_05: switch code 00 ignores events
// RULE_06: switch code 10 disables, ties negative supply
// RULE_07: switch code 11 disables, clamp bit chooses
// RULE_08: group A switch fields bits 11-8
// RULE_09: converter enable 1 powers down on event
// RULE_10: converter enable 0 keeps converter running
// RULE_11: first A converter source register routes alarms
// RULE_12: A converter events obey per-converter enables
// RULE_13: second A converter source upper alarms
// RULE_14: second A converter source supply alarms
// RULE_15: first A switch source register routes alarms
// RULE_16: A switch events obey switch fields
// RULE_17: second A switch source upper alarms
// RULE_18: second A switch source supply alarms
// RULE_19: event is OR, held while alarms persist
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module bias_auto_powerdown_cfg
	import bias_apd_pkg::*;
(
	input  wire logic               ref_clk,
	input  wire logic               reset_n,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic               hready,
	input  wire logic [31:0]        hwdata,
	input  wire logic [ALARM_W-1:0] external_alarm_input,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	output logic [7:0]              convPowerDown,
	output logic [3:0]              swDriveOff,
	output logic [3:0]              swTieNegSupply,
	output logic [3:0]              swClampToConv,
	output logic                    grpABipolar,
	output logic                    grpBBipolar
);

	// ----------------------------------------------------------------
	// declarations: bus slave and storage
	// ----------------------------------------------------------------
	logic [15:0]        regFile_reg [NUM_REGS];
	logic               wrPend_reg;
	logic [2:0]         wrSlot_reg;
	logic [31:0]        hrdata_reg;
	logic               hreadyout_reg;
	logic               hresp_reg;

	// ----------------------------------------------------------------
	// declarations: alarm synchroniser
	// ----------------------------------------------------------------
	logic [ALARM_W-1:0] alarmMeta_reg;
	logic [ALARM_W-1:0] alarmSync_reg;

	// ----------------------------------------------------------------
	// declarations: output flops and their next values
	// ----------------------------------------------------------------
	logic [7:0]         convPowerDown_reg;
	logic [7:0]         convPowerDown_next;
	logic [3:0]         swDriveOff_reg;
	logic [3:0]         swDriveOff_next;
	logic [3:0]         swTieNeg_reg;
	logic [3:0]         swTieNeg_next;
	logic [3:0]         swClamp_reg;
	logic [3:0]         swClamp_next;
	logic               grpABipolar_reg;
	logic               grpBBipolar_reg;

	// ----------------------------------------------------------------
	// declarations: decode helpers
	// ----------------------------------------------------------------
	logic               addrPhase;
	logic               addrHit;
	logic [2:0]         addrSlot;
	logic [15:0]        readValue;

	// ----------------------------------------------------------------
	// declarations: routing and events
	// ----------------------------------------------------------------
	logic [ALARM_W-1:0] aConvRoute;
	logic [ALARM_W-1:0] aSwRoute;
	logic [ALARM_W-1:0] bConvRoute;
	logic               evtAConv;
	logic               evtASw;
	logic               evtBConv;

	// ----------------------------------------------------------------
	// bus slave: address phase decode
	// ----------------------------------------------------------------
	assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);

	always_comb begin
		addrHit  = 1'b0;
		addrSlot = 3'h0;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (haddr[31:10] == 22'h0 && haddr[9:2] == REG_INDEX[i]) begin
				addrHit  = 1'b1;
				addrSlot = 3'(i);
			end
		end
	end

	// ----------------------------------------------------------------
	// bus slave: read forwarding
	// ----------------------------------------------------------------
	// forward a write that commits on this same edge, so a read right
	// behind a write to the same register sees the new value
	always_comb begin
		readValue = 16'h0000;
		if (addrHit) begin
			if (wrPend_reg && wrSlot_reg == addrSlot) begin
				readValue = hwdata[15:0] & REG_WMASK[addrSlot];
			end else begin
				readValue = regFile_reg[addrSlot];
			end
		end
	end

	// ----------------------------------------------------------------
	// bus slave: write capture, read data, response
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wrPend_reg <= 1'b0;
		end else if (hready) begin
			// narrower writes are ignored; only whole words are defined
			wrPend_reg <= addrPhase & hwrite & addrHit & (hsize == HSIZE_WORD);
		end
	end

	// slot is kept apart from the pending flag; it only matters while pending
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wrSlot_reg <= 3'h0;
		end else if (hready) begin
			wrSlot_reg <= addrSlot;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			hrdata_reg <= {16'h0000, readValue};
		end else begin
			hrdata_reg <= 32'h0000_0000;
		end
	end

	// zero wait states, always OKAY
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			hreadyout_reg <= 1'b1;
		end else begin
			hreadyout_reg <= 1'b1;
		end
	end

	// no error case exists: unmapped accesses and narrow writes are simply dropped
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			hresp_reg <= HRESP_OKAY;
		end else begin
			hresp_reg <= HRESP_OKAY;
		end
	end

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NUM_REGS; g++) begin : gen_regs
		always_ff @(posedge ref_clk or negedge reset_n) begin
			if (!reset_n) begin
				regFile_reg[g] <= REG_RESET[g];
			end else if (wrPend_reg && wrSlot_reg == 3'(g)) begin
				regFile_reg[g] <= hwdata[15:0] & REG_WMASK[g];
			end
		end
	end

	// ----------------------------------------------------------------
	// alarm synchroniser
	// ----------------------------------------------------------------
	// first stage may go metastable; nothing but the second stage reads it
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			alarmMeta_reg <= '0;
		end else begin
			alarmMeta_reg <= external_alarm_input;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			alarmSync_reg <= '0;
		end else begin
			alarmSync_reg <= alarmMeta_reg;
		end
	end

	// ----------------------------------------------------------------
	// alarm routing into group events
	// ----------------------------------------------------------------
	function automatic logic [ALARM_W-1:0] route(input logic [15:0] lo, input logic [15:0] hi);
		logic [ALARM_W-1:0] r;
		r                   = '0;
		r[ALM_TEMP]         = lo[TEMP_ALARM_ROUTE];
		r[ALM_EXT_IN1]      = lo[EXT_IN1_ALARM_ROUTE];
		r[ALM_EXT_IN0]      = lo[EXT_IN0_ALARM_ROUTE];
		r[ALM_ISENSE1]      = lo[ISENSE1_ALARM_ROUTE];
		r[ALM_ISENSE0]      = lo[ISENSE0_ALARM_ROUTE];
		r[ALM_PIN]          = hi[ALARM_PIN_ROUTE];
		r[ALM_VREF]         = hi[VREF_ALARM_ROUTE];
		r[ALM_THERMAL_ERR]  = hi[THERMAL_ERR_ROUTE];
		r[ALM_NEG_SUPPLY_B] = hi[NEG_SUPPLY_B_ROUTE];
		r[ALM_NEG_SUPPLY_A] = hi[NEG_SUPPLY_A_ROUTE];
		r[ALM_POS_SUPPLY_B] = hi[POS_SUPPLY_B_ROUTE];
		r[ALM_POS_SUPPLY_A] = hi[POS_SUPPLY_A_ROUTE];
		return r;
	endfunction

	assign aConvRoute = route(regFile_reg[SLOT_A_CONV_LO], regFile_reg[SLOT_A_CONV_HI]); // RULE_11
	assign aSwRoute   = route(regFile_reg[SLOT_A_SW_LO], regFile_reg[SLOT_A_SW_HI]); // RULE_15
	// group B's second source register lives elsewhere; only its first half is here
	assign bConvRoute = route(regFile_reg[SLOT_B_CONV_LO], 16'h0000);

	// ----------------------------------------------------------------
	// group A converter event
	// ----------------------------------------------------------------
	// level event: held exactly as long as a routed alarm stays active
	assign evtAConv = |(alarmSync_reg & aConvRoute); // RULE_13 RULE_14 RULE_19

	// ----------------------------------------------------------------
	// group A switch event
	// ----------------------------------------------------------------
	assign evtASw   = |(alarmSync_reg & aSwRoute); // RULE_17 RULE_18 RULE_19

	// ----------------------------------------------------------------
	// group B event
	// ----------------------------------------------------------------
	// no sticky latch: the alarm source itself must hold its level
	assign evtBConv = |(alarmSync_reg & bConvRoute);

	// ----------------------------------------------------------------
	// converter power-down
	// ----------------------------------------------------------------
	for (genvar c = 0; c < 8; c++) begin : gen_conv
		// converters 0..3 are group A, 4..7 group B
		assign convPowerDown_next[c] = regFile_reg[SLOT_APD_EN][CONV_PD_ENABLE_LSB + c] &
			((c < 4) ? evtAConv : evtBConv); // RULE_09 RULE_10 RULE_12
	end

	// ----------------------------------------------------------------
	// switch outputs: 0=A0, 1=A2, 2=B0, 3=B2
	// ----------------------------------------------------------------
	for (genvar s = 0; s < 4; s++) begin : gen_sw
		logic [1:0] swPdMode;
		logic       clampSrc;
		logic       swEvt;
		assign swPdMode = regFile_reg[SLOT_APD_EN][SW_PD_MODE_LSB + 2 * s +: 2]; // RULE_08
		assign clampSrc = regFile_reg[SLOT_CFG][CLAMP_SRC_LSB + s]; // RULE_03 RULE_04
		// group B switches follow the group B converter event
		assign swEvt    = (s < 2) ? evtASw : evtBConv; // RULE_16

		always_comb begin
			swDriveOff_next[s] = 1'b0;
			swTieNeg_next[s]   = 1'b0;
			swClamp_next[s]    = 1'b0;
			case (swPdMode)
				SW_PD_IGNORE: begin
					swDriveOff_next[s] = 1'b0; // RULE_05
				end
				SW_PD_TO_NEG: begin
					swDriveOff_next[s] = swEvt; // RULE_06
					swTieNeg_next[s]   = swEvt; // RULE_06
				end
				SW_PD_CLAMP: begin
					swDriveOff_next[s] = swEvt; // RULE_07
					swTieNeg_next[s]   = swEvt & ~clampSrc; // RULE_07
					swClamp_next[s]    = swEvt & clampSrc; // RULE_07
				end
				default: begin
					// undefined code 01 treated as ignore
					swDriveOff_next[s] = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// output registers, one per concern
	// ----------------------------------------------------------------
	// every pin comes straight from a flop, so the analog side never
	// sees a glitch from the routing logic in front of it
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			convPowerDown_reg <= 8'h00;
		end else begin
			convPowerDown_reg <= convPowerDown_next;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			swDriveOff_reg <= 4'h0;
		end else begin
			swDriveOff_reg <= swDriveOff_next;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			swTieNeg_reg <= 4'h0;
		end else begin
			swTieNeg_reg <= swTieNeg_next;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			swClamp_reg <= 4'h0;
		end else begin
			swClamp_reg <= swClamp_next;
		end
	end

	// ----------------------------------------------------------------
	// polarity outputs
	// ----------------------------------------------------------------
	// a registered copy: polarity follows one cycle after the write commits
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			grpABipolar_reg <= 1'b0;
		end else begin
			grpABipolar_reg <= regFile_reg[SLOT_CFG][GRP_A_BIPOLAR_SEL]; // RULE_02
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			grpBBipolar_reg <= 1'b0;
		end else begin
			grpBBipolar_reg <= regFile_reg[SLOT_CFG][GRP_B_BIPOLAR_SEL]; // RULE_01
		end
	end

	// ----------------------------------------------------------------
	// port connections
	// ----------------------------------------------------------------
	assign hrdata         = hrdata_reg;
	assign hreadyout      = hreadyout_reg;
	assign hresp          = hresp_reg;
	assign convPowerDown  = convPowerDown_reg;
	assign swDriveOff     = swDriveOff_reg;
	assign swTieNegSupply = swTieNeg_reg;
	assign swClampToConv  = swClamp_reg;
	assign grpABipolar    = grpABipolar_reg;
	assign grpBBipolar    = grpBBipolar_reg;

endmodule

`default_nettype wire

// ---- sim/bias_apd_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module bias_apd_props
	import bias_apd_pkg::*;
(
	input wire logic               ref_clk,
	input wire logic               reset_n,
	input wire logic               hsel,
	input wire logic [31:0]        haddr,
	input wire logic [1:0]         htrans,
	input wire logic               hwrite,
	input wire logic [2:0]         hsize,
	input wire logic               hready,
	input wire logic [31:0]        hwdata,
	input wire logic [ALARM_W-1:0] external_alarm_input,
	input wire logic [31:0]        hrdata,
	input wire logic               hreadyout,
	input wire logic               hresp,
	input wire logic [7:0]         convPowerDown,
	input wire logic [3:0]         swDriveOff,
	input wire logic [3:0]         swTieNegSupply,
	input wire logic [3:0]         swClampToConv,
	input wire logic               grpABipolar,
	input wire logic               grpBBipolar
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire logic       wrTaken = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
	wire logic [3:0] swPin   = swTieNegSupply | swClampToConv;

	AST_DRV_HAS_PIN: assert property (swDriveOff == swPin)
		else $error("drive off and pin connection disagree");
	AST_TIE_CLAMP_EXCL: assert property ((swTieNegSupply & swClampToConv) == 4'h0)
		else $error("pin tied and clamped at once");
	AST_QUIET_CLEARS: assert property ((external_alarm_input == '0) [*3] |=> swPin == 4'h0 && convPowerDown == 8'h00)
		else $error("outputs held with no alarm");
	AST_CONV_NEEDS_ALARM: assert property (convPowerDown != 8'h00 |-> $past(external_alarm_input, 3) != '0)
		else $error("converter down without earlier alarm");
	AST_GRP_B_LOW_ONLY: assert property ((external_alarm_input[4:0] == 5'h0) [*3] |=> swPin[3:2] == 2'h0 && convPowerDown[7:4] == 4'h0)
		else $error("group B reacted to an unrouted alarm");
	AST_CONV_HOLD: assert property (($stable(external_alarm_input) && !wrTaken) [*4] |=> $stable(convPowerDown))
		else $error("converter power-down moved without cause");
	AST_SW_HOLD: assert property (($stable(external_alarm_input) && !wrTaken) [*4] |=> $stable(swPin))
		else $error("switch state moved without cause");
	AST_BIPOLAR_HOLD: assert property (!wrTaken [*3] |=> $stable({grpABipolar, grpBBipolar}))
		else $error("polarity moved without a write");

	COV_WRITE: cover property (wrTaken);
	COV_CONV_DOWN: cover property (convPowerDown != 8'h00);
	COV_CLAMP: cover property (swClampToConv != 4'h0);
endmodule

bind bias_auto_powerdown_cfg bias_apd_props bias_apd_props_i (
	.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .external_alarm_input(external_alarm_input),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .convPowerDown(convPowerDown),
	.swDriveOff(swDriveOff), .swTieNegSupply(swTieNegSupply), .swClampToConv(swClampToConv),
	.grpABipolar(grpABipolar), .grpBBipolar(grpBBipolar));
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import bias_apd_pkg::*;
;
	logic               refClk, resetN, hsel, hwrite, hreadyout, hresp;
	logic [31:0]        haddr, hwdata, hrdata;
	logic [1:0]         htrans;
	logic [2:0]         hsize;
	logic [ALARM_W-1:0] external_alarm_input;
	logic [7:0]         convPowerDown;
	logic [3:0]         swDriveOff, swTieNegSupply, swClampToConv;
	logic               grpABipolar, grpBBipolar;
	logic               lastResp;
	int                 nErrors = 0;
	int                 cmpCount = 0;
	int                 cycles = 0;
	// source bit of each alarm input, low half for 0..4
	localparam int ROUTE [ALARM_W] = '{8, 5, 4, 1, 0, 13, 12, 11, 5, 4, 1, 0};

	bias_auto_powerdown_cfg bias_auto_powerdown_cfg_i (
		.ref_clk(refClk), .reset_n(resetN), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.external_alarm_input(external_alarm_input), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.convPowerDown(convPowerDown), .swDriveOff(swDriveOff),
		.swTieNegSupply(swTieNegSupply), .swClampToConv(swClampToConv),
		.grpABipolar(grpABipolar), .grpBBipolar(grpBBipolar));

	initial begin
		refClk = 1'b0;
		forever #12.5 refClk = ~refClk;
	end

	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("errors %0d comparisons %0d", nErrors, cmpCount);
		if (nErrors == 0 && cmpCount > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmpCount++;
		if (got !== exp) begin
			nErrors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	always @(posedge refClk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			nErrors++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// bus master, entered just after a rising edge
	// ----------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		do @(posedge refClk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {16'h0, wd};
		do @(posedge refClk); while (hreadyout !== 1'b1);
		rd = hrdata;
		lastResp = hresp;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [15:0] d);
		logic [31:0] x;
		xfer(1'b1, idx, d, x);
	endtask

	task automatic rdchk(input logic [7:0] idx, input logic [15:0] e);
		logic [31:0] x;
		xfer(1'b0, idx, 16'h0, x);
		chk("hrdata", {16'h0, e}, x);
		chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, lastResp});
	endtask

	// expected outputs packed as conv, drive off, tie, clamp
	task automatic alarmCase(input int i, input logic [15:0] apd, cfg, input logic [19:0] e);
		logic [15:0] r;
		logic [7:0]  sel;
		r = 16'h1 << ROUTE[i];
		sel = (i < 5) ? 8'h0 : 8'h1;
		wr(IDX_APD_EN, apd);
		wr(IDX_CFG, cfg);
		for (int k = 0; k < 5; k++) begin
			wr(IDX_A_CONV_LO + 8'(k), 16'h0);
		end
		external_alarm_input <= ALARM_W'(1) << i;
		repeat (4) @(posedge refClk);
		chk("unrouted", 32'h0, {12'h0, convPowerDown, swDriveOff, swPin()});
		wr(IDX_A_CONV_LO + sel, r);
		wr(IDX_A_SW_LO + sel, r);
		wr(IDX_B_CONV_LO, (i < 5) ? r : 16'h0);
		repeat (4) @(posedge refClk);
		chk("routed", {12'h0, e}, {12'h0, convPowerDown, swDriveOff, swPin()});
		external_alarm_input <= '0;
		repeat (4) @(posedge refClk);
		chk("released", 32'h0, {12'h0, convPowerDown, swDriveOff, swPin()});
	endtask

	function automatic logic [7:0] swPin();
		return {swTieNegSupply, swClampToConv};
	endfunction

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		resetN = 1'b0;
		{hsel, hwrite, haddr, hwdata, htrans, hsize, external_alarm_input} = '0;
		repeat (2) @(posedge refClk);
		resetN <= 1'b1;
		@(posedge refClk);
		for (int k = 0; k < NUM_REGS; k++) begin
			rdchk(REG_INDEX[k], REG_RESET[k]);
		end
		for (int k = 0; k < NUM_REGS; k++) begin
			wr(REG_INDEX[k], 16'hffff);
			rdchk(REG_INDEX[k], REG_WMASK[k]);
		end
		wr(8'h49, 16'hffff);
		rdchk(8'h49, 16'h0);
		repeat (3) @(posedge refClk);
		chk("polarity", 32'h3, {30'h0, grpBBipolar, grpABipolar});
		wr(IDX_CFG, 16'h1000);
		repeat (3) @(posedge refClk);
		chk("polarity", 32'h1, {30'h0, grpBBipolar, grpABipolar});
		// a lone low-half alarm also reaches group B through its own source
		for (int i = 0; i < ALARM_W; i++) begin
			alarmCase(i, 16'hce5a, 16'h0008, (i < 5) ? 20'h5ab38 : 20'h0a330);
		end
		alarmCase(0, 16'h0f00, 16'h0001, 20'h00321);
		finish_test();
	end
endmodule
`default_nettype wire
